// [hw/cbts_consts.svh]
`ifndef CBTS_CONSTS_SVH
`define CBTS_CONSTS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CBTS_OFF_BAUD 12'h000
`define CBTS_OFF_SEG 12'h004
`define CBTS_OFF_CTRL 12'h008
`define CBTS_OFF_STAT 12'h00C

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CBTS_BRP_LSB 0
`define CBTS_BRP_MSB 5
`define CBTS_SJW_LSB 6
`define CBTS_SJW_MSB 7
`define CBTS_PRS_LSB 0
`define CBTS_PRS_MSB 2
`define CBTS_PH1_LSB 3
`define CBTS_PH1_MSB 5
`define CBTS_SAM_BIT 6
`define CBTS_PH2SEL_BIT 7
`define CBTS_PH2_LSB 8
`define CBTS_PH2_MSB 10
`define CBTS_WAKF_BIT 14
`define CBTS_EN_BIT 0

// ------------------------------------------------------------
// reset values and write masks
// ------------------------------------------------------------
`define CBTS_BAUD_RST 8'h00
`define CBTS_SEG_RST 16'h0000
`define CBTS_SEG_MASK 16'h47FF
`define CBTS_CTRL_RST 1'h0

// ------------------------------------------------------------
// timing counts
// ------------------------------------------------------------
`define CBTS_IPT_TQ 5'h02
`define CBTS_WAKE_FILT_CYC 4'h4

`endif

// [hw/cbts_pkg.sv]
package cbts_pkg;

  typedef enum logic [3:0] {
    CBTS_SYNC = 4'h1,
    CBTS_PROP = 4'h2,
    CBTS_PH1 = 4'h4,
    CBTS_PH2 = 4'h8
  } cbts_seg_t;

endpackage

// [hw/cbts_quantum_gen.sv]
`timescale 1ns/1ns
`default_nettype none

module cbts_quantum_gen #(
  parameter int PW = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [PW-1:0] prescaler,
  output logic tq_tick
);

  logic [PW:0] cnt_reg;
  logic [PW:0] last;

  // ------------------------------------------------------------
  // quantum = 2 x (code + 1) clock periods
  // ------------------------------------------------------------
  assign last = {prescaler, 1'b1};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (!run || cnt_reg == last) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tq_tick <= 1'b0;
    end else begin
      tq_tick <= run && cnt_reg == last;
    end
  end

endmodule

`default_nettype wire

// [hw/cbts_top.sv]
`timescale 1ns/1ns
`include "cbts_consts.svh"
`default_nettype none

module cbts_top #(
  parameter int PW = 6,
  parameter logic [4:0] IPT_TQ = `CBTS_IPT_TQ,
  parameter logic [3:0] WAKE_FILT_CYC = `CBTS_WAKE_FILT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic can_rx,
  output logic sampled_bit,
  output logic sample_point,
  output logic bit_start,
  output logic wake_event
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] baud_reg;
  logic [15:0] seg_reg;
  logic ctrl_en_reg;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [31:0] rdata_next;

  cbts_pkg::cbts_seg_t state_reg;
  logic [4:0] q_cnt_reg;
  logic [4:0] ext_reg;
  logic [4:0] shrink_reg;
  logic resynced_reg;
  logic rx_prev_reg;
  logic [1:0] hist_reg;
  logic [3:0] filt_cnt_reg;
  logic tq_tick;

  logic [4:0] prop_len;
  logic [4:0] ph1_len;
  logic [4:0] ph1_base;
  logic [4:0] ph2_len;
  logic [4:0] sjw_len;
  logic [4:0] target;
  logic [4:0] elapsed;
  logic [4:0] remain;
  logic seg_end;
  logic rx_fall;
  logic vote;

  // ------------------------------------------------------------
  // apb decode, one wait state
  // ------------------------------------------------------------
  assign rd_en = psel && penable && !pwrite && !pready;
  assign wr_en = psel && penable && pwrite && pready;
  assign mapped = paddr == `CBTS_OFF_BAUD || paddr == `CBTS_OFF_SEG ||
                  paddr == `CBTS_OFF_CTRL || paddr == `CBTS_OFF_STAT;

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      `CBTS_OFF_BAUD: rdata_next = {24'h000000, baud_reg};
      `CBTS_OFF_SEG: rdata_next = {16'h0000, seg_reg};
      `CBTS_OFF_CTRL: rdata_next = {31'h0000_0000, ctrl_en_reg};
      `CBTS_OFF_STAT: rdata_next = {26'h000_0000, rx_prev_reg,
                                    sampled_bit, state_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (rd_en) begin
        prdata <= rdata_next;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_reg <= `CBTS_BAUD_RST;
      seg_reg <= `CBTS_SEG_RST;
      ctrl_en_reg <= `CBTS_CTRL_RST;
    end else if (wr_en) begin
      if (paddr == `CBTS_OFF_BAUD) begin
        baud_reg <= pwdata[7:0];
      end
      if (paddr == `CBTS_OFF_SEG) begin
        seg_reg <= pwdata[15:0] & `CBTS_SEG_MASK;
      end
      if (paddr == `CBTS_OFF_CTRL) begin
        ctrl_en_reg <= pwdata[`CBTS_EN_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // time quantum
  // ------------------------------------------------------------
  cbts_quantum_gen #(.PW(PW)) u_tq (
    .pclk(pclk),
    .presetn(presetn),
    .run(ctrl_en_reg),
    .prescaler(baud_reg[`CBTS_BRP_MSB:`CBTS_BRP_LSB]),
    .tq_tick(tq_tick)
  );

  // ------------------------------------------------------------
  // segment lengths in quanta
  // ------------------------------------------------------------
  assign prop_len = {2'b00, seg_reg[`CBTS_PRS_MSB:`CBTS_PRS_LSB]} + 5'h01;
  assign ph1_base = {2'b00, seg_reg[`CBTS_PH1_MSB:`CBTS_PH1_LSB]} + 5'h01;
  assign ph1_len = ph1_base + ext_reg;
  assign sjw_len = {3'b000, baud_reg[`CBTS_SJW_MSB:`CBTS_SJW_LSB]} + 5'h01;

  always_comb begin
    if (seg_reg[`CBTS_PH2SEL_BIT]) begin
      ph2_len = {2'b00, seg_reg[`CBTS_PH2_MSB:`CBTS_PH2_LSB]} + 5'h01;
    end else if (ph1_base > IPT_TQ) begin
      ph2_len = ph1_base;
    end else begin
      ph2_len = IPT_TQ;
    end
  end

  always_comb begin
    case (state_reg)
      cbts_pkg::CBTS_SYNC: target = 5'h01;
      cbts_pkg::CBTS_PROP: target = prop_len;
      cbts_pkg::CBTS_PH1: target = ph1_len;
      cbts_pkg::CBTS_PH2: target = ph2_len - shrink_reg;
      default: target = 5'h01;
    endcase
  end

  assign seg_end = tq_tick && (q_cnt_reg + 5'h01 >= target);
  assign rx_fall = rx_prev_reg && !can_rx;
  assign remain = target - q_cnt_reg;
  assign elapsed = (state_reg == cbts_pkg::CBTS_PH1) ?
                   prop_len + q_cnt_reg + 5'h01 : q_cnt_reg + 5'h01;
  assign vote = (hist_reg[0] & hist_reg[1]) | (hist_reg[0] & can_rx) |
                (hist_reg[1] & can_rx);

  // ------------------------------------------------------------
  // bit segment sequencer
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= cbts_pkg::CBTS_SYNC;
      q_cnt_reg <= 5'h00;
    end else if (!ctrl_en_reg) begin
      state_reg <= cbts_pkg::CBTS_SYNC;
      q_cnt_reg <= 5'h00;
    end else if (rx_fall && !resynced_reg &&
                 state_reg == cbts_pkg::CBTS_PH2 && remain <= sjw_len) begin
      state_reg <= cbts_pkg::CBTS_SYNC;
      q_cnt_reg <= 5'h00;
    end else if (seg_end) begin
      q_cnt_reg <= 5'h00;
      case (state_reg)
        cbts_pkg::CBTS_SYNC: state_reg <= cbts_pkg::CBTS_PROP;
        cbts_pkg::CBTS_PROP: state_reg <= cbts_pkg::CBTS_PH1;
        cbts_pkg::CBTS_PH1: state_reg <= cbts_pkg::CBTS_PH2;
        cbts_pkg::CBTS_PH2: state_reg <= cbts_pkg::CBTS_SYNC;
        default: state_reg <= cbts_pkg::CBTS_SYNC;
      endcase
    end else if (tq_tick) begin
      q_cnt_reg <= q_cnt_reg + 5'h01;
    end
  end

  // ------------------------------------------------------------
  // resynchronisation, one per bit
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_reg <= 5'h00;
      shrink_reg <= 5'h00;
      resynced_reg <= 1'b0;
    end else if (!ctrl_en_reg || (seg_end &&
                 state_reg == cbts_pkg::CBTS_PH2) ||
                 state_reg == cbts_pkg::CBTS_SYNC) begin
      ext_reg <= 5'h00;
      shrink_reg <= 5'h00;
      resynced_reg <= 1'b0;
    end else if (rx_fall && !resynced_reg) begin
      resynced_reg <= 1'b1;
      if (state_reg == cbts_pkg::CBTS_PH2) begin
        shrink_reg <= sjw_len;
      end else begin
        ext_reg <= (elapsed < sjw_len) ? elapsed : sjw_len;
      end
    end
  end

  // ------------------------------------------------------------
  // sample point
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_reg <= 2'b11;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= can_rx;
      if (tq_tick) begin
        hist_reg <= {hist_reg[0], can_rx};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampled_bit <= 1'b1;
      sample_point <= 1'b0;
      bit_start <= 1'b0;
    end else begin
      sample_point <= seg_end && state_reg == cbts_pkg::CBTS_PH1;
      bit_start <= seg_end && state_reg == cbts_pkg::CBTS_SYNC;
      if (seg_end && state_reg == cbts_pkg::CBTS_PH1) begin
        sampled_bit <= seg_reg[`CBTS_SAM_BIT] ? vote : can_rx;
      end
    end
  end

  // ------------------------------------------------------------
  // wake detection
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_cnt_reg <= 4'h0;
    end else if (can_rx) begin
      filt_cnt_reg <= 4'h0;
    end else if (filt_cnt_reg != WAKE_FILT_CYC) begin
      filt_cnt_reg <= filt_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_event <= 1'b0;
    end else if (seg_reg[`CBTS_WAKF_BIT]) begin
      wake_event <= !can_rx && filt_cnt_reg == WAKE_FILT_CYC - 4'h1;
    end else begin
      wake_event <= rx_fall;
    end
  end

endmodule

`default_nettype wire

// [tb/cbts_bus_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ----
// bus line: recessive idle, low pulse on go
// ----
module cbts_bus_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [7:0] low_len,
  output logic can_rx
);
  logic [7:0] cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
    end else if (go) begin
      cnt_reg <= low_len;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
  assign can_rx = (cnt_reg == 8'h00);
endmodule
`default_nettype wire

// [tb/cbts_top_properties.sv]
`timescale 1ns/1ns
`default_nettype none
// ----
// port checker
// ----
module cbts_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sampled_bit,
  input wire logic sample_point,
  input wire logic bit_start,
  input wire logic wake_event
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ack_one_wait_a:
    assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  ack_single_a:
    assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ack_a:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a:
    assert property (pready &&
      !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}) |-> pslverr)
    else $error("no pslverr on unmapped address");
  mapped_ok_a:
    assert property (pready &&
      (paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}) |-> !pslverr)
    else $error("pslverr on mapped address");
  unmapped_zero_a:
    assert property (pready && !pwrite &&
      !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}) |->
      prdata == 32'h0)
    else $error("unmapped read not zero");
  sample_pulse_a:
    assert property (sample_point |=> !sample_point)
    else $error("sample point pulse too long");
  start_pulse_a:
    assert property (bit_start |=> !bit_start)
    else $error("bit start pulse too long");
  sample_order_a:
    assert property (sample_point |-> !bit_start)
    else $error("sample point on bit start");
  sample_change_a:
    assert property (!$stable(sampled_bit) |-> sample_point)
    else $error("sampled bit moved off sample point");
  wake_pulse_a:
    assert property (wake_event |=> !wake_event)
    else $error("wake pulse too long");
endmodule
bind cbts_top cbts_checker i_cbts_checker (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .sampled_bit, .sample_point,
  .bit_start, .wake_event);
`default_nettype wire

// [tb/test_can_bit_timing_segments.sv]
`timescale 1ns/1ns
`default_nettype none
// ----
// testbench
// ----
module test_can_bit_timing_segments;
  typedef struct {
    logic [7:0] baud;
    logic [15:0] seg;
    logic [15:0] per;
    logic [15:0] spo;
  } cbts_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, can_rx, sampled_bit, sample_point, bit_start;
  logic wake_event;
  logic go = 1'b0;
  logic [7:0] low_len = 8'h00;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int per, spo, nw, pj;
  logic [31:0] rd;
  logic er;
  cbts_row_t rows [6] = '{
    '{8'h00, 16'h0080, 16'h0008, 16'h0004},
    '{8'h01, 16'h0080, 16'h0010, 16'h0008},
    '{8'h02, 16'h0080, 16'h0018, 16'h000C},
    '{8'h00, 16'h07BF, 16'h0032, 16'h0020},
    '{8'h00, 16'h0000, 16'h000A, 16'h0004},
    '{8'h00, 16'h0728, 16'h001C, 16'h000E}};
  always #25 pclk = ~pclk;
  cbts_top i_cbts_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .can_rx, .sampled_bit,
    .sample_point, .bit_start, .wake_event);
  cbts_bus_model i_cbts_bus_model (.pclk, .presetn, .go, .low_len, .can_rx);
  task automatic results();
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic meas();
    int n;
    n = 0;
    while (bit_start !== 1'b1 && n < 400) begin
      n++;
      @(posedge pclk);
    end
    spo = 0;
    do begin
      @(posedge pclk);
      spo++;
    end while (sample_point !== 1'b1 && spo < 400);
    per = spo;
    do begin
      @(posedge pclk);
      per++;
    end while (bit_start !== 1'b1 && per < 400);
  endtask
  // falling edge one quantum into propagation, next bit start counted
  task automatic jump(input logic [7:0] b, output int p);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h000, {24'h0, b});
    apb(1'b1, 12'h004, 32'h000007BF);
    apb(1'b1, 12'h008, 32'h1);
    meas();
    go <= 1'b1;
    low_len <= 8'h04;
    p = 0;
    do begin
      @(posedge pclk);
      go <= 1'b0;
      p++;
    end while (bit_start !== 1'b1 && p < 400);
  endtask
  // one-clock low glitch just before the sample point
  task automatic glitch(input logic [15:0] s);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, {16'h0, s});
    apb(1'b1, 12'h008, 32'h1);
    meas();
    @(posedge pclk);
    go <= 1'b1;
    low_len <= 8'h01;
    @(posedge pclk);
    go <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic wake(input logic [7:0] len);
    go <= 1'b1;
    low_len <= len;
    @(posedge pclk);
    go <= 1'b0;
    nw = 0;
    repeat (20) begin
      @(posedge pclk);
      if (wake_event === 1'b1) begin
        nw++;
      end
    end
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk("baud_rst", 32'h0, rd);
    apb(1'b0, 12'h004, 32'h0);
    chk("seg_rst", 32'h0, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("ctrl_rst", 32'h0, rd);
    apb(1'b1, 12'h004, 32'hFFFFFFFF);
    apb(1'b0, 12'h004, 32'h0);
    chk("seg_mask", 32'h000047FF, rd);
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    chk("unmapped_err", 32'h1, {31'h0, er});
    apb(1'b0, 12'h002, 32'h0);
    chk("unmapped_rd", 32'h0, rd);
    chk("unmapped_rd_err", 32'h1, {31'h0, er});
    apb(1'b0, 12'h00C, 32'h0);
    chk("stat_rst", 32'h00000031, rd);
    chk("mapped_err", 32'h0, {31'h0, er});
    foreach (rows[i]) begin
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b1, 12'h000, {24'h0, rows[i].baud});
      apb(1'b1, 12'h004, {16'h0, rows[i].seg});
      apb(1'b1, 12'h008, 32'h1);
      meas();
      chk("bit_period", {16'h0, rows[i].per}, per);
      chk("sample_ofs", {16'h0, rows[i].spo}, spo);
    end
    jump(8'h00, pj);
    chk("jump_capped", 32'h34, pj);
    jump(8'hC0, pj);
    chk("jump_elapsed", 32'h36, pj);
    glitch(16'h0080);
    chk("single_glitch", 32'h0, {31'h0, sampled_bit});
    glitch(16'h00C0);
    chk("triple_glitch", 32'h1, {31'h0, sampled_bit});
    apb(1'b1, 12'h004, 32'h00000080);
    wake(8'h02);
    chk("wake_unfilt", 32'h1, nw);
    apb(1'b1, 12'h004, 32'h00004080);
    wake(8'h03);
    chk("wake_short", 32'h0, nw);
    wake(8'h06);
    chk("wake_long", 32'h1, nw);
    apb(1'b1, 12'h004, 32'h000000C0);
    wake(8'hC8);
    chk("triple_low", 32'h0, {31'h0, sampled_bit});
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("bit_rst", 32'h1, {31'h0, sampled_bit});
    apb(1'b0, 12'h004, 32'h0);
    chk("seg_rst2", 32'h0, rd);
    results();
  end
endmodule
`default_nettype wire
